// ---- src/mmd_pkg.sv ----
/*
  Package for the memory map decoder: region bounds, fixed words, peripheral windows,
  descriptor addresses and the CRC polynomial.
  Assumes a 20-bit byte address space and a 16-bit data bus.
*/
package mmd_pkg;
  // ----------------------------------------------------------------
  // Regions
  // ----------------------------------------------------------------
  localparam logic [19:0] RSV_LO = 20'h00000;
  localparam logic [19:0] RSV_HI = 20'h00005;
  localparam logic [19:0] TINY_LO = 20'h00006;
  localparam logic [19:0] TINY_HI = 20'h0001F;
  localparam logic [19:0] PERIPH_LO = 20'h00020;
  localparam logic [19:0] PERIPH_HI = 20'h00FFF;
  localparam logic [19:0] BOOTLO_LO = 20'h01000;
  localparam logic [19:0] BOOTLO_HI = 20'h017FF;
  localparam logic [19:0] INFO_LO = 20'h01800;
  localparam logic [19:0] INFO_HI = 20'h019FF;
  localparam logic [19:0] DESC_LO = 20'h01A00;
  localparam logic [19:0] DESC_HI = 20'h01A31;
  localparam logic [19:0] RAM_LO = 20'h02000;
  localparam logic [19:0] RAM_HI = 20'h03FFF;
  localparam logic [19:0] PROG_LO = 20'h08000;
  localparam logic [19:0] PROG_HI = 20'h17FFF;
  localparam logic [19:0] BOOTHI_LO = 20'hFFC00;
  localparam logic [19:0] BOOTHI_HI = 20'hFFFFF;
  // ----------------------------------------------------------------
  // Fixed reserved words
  // ----------------------------------------------------------------
  localparam logic [15:0] RSV_WORD0 = 16'hD032;
  localparam logic [15:0] RSV_WORD1 = 16'h00F0;
  localparam logic [15:0] RSV_WORD2 = 16'h3FFF;
  // ----------------------------------------------------------------
  // Peripheral windows
  // ----------------------------------------------------------------
  localparam logic [19:0] SFR_BASE = 20'h00100;
  localparam logic [19:0] SFR_SIZE = 20'h00010;
  localparam logic [19:0] CRCP_BASE = 20'h001C0;
  localparam logic [19:0] CRCP_SIZE = 20'h00008;
  localparam logic [19:0] SERB0_BASE = 20'h00540;
  localparam logic [19:0] SERB0_SIZE = 20'h00030;
  localparam logic [19:0] PORT_BASE = 20'h00200;
  localparam logic [19:0] PORT_SIZE = 20'h00060;
  localparam logic [4:0] PORT_WIN_MASK = 5'h1F;
  localparam logic [4:0] PORT_VEC_LO = 5'h0E;
  localparam logic [4:0] PORT_VEC_HI = 5'h1E;
  // ----------------------------------------------------------------
  // Descriptor record
  // ----------------------------------------------------------------
  localparam logic [19:0] DESC_CRC_ADDR = 20'h01A02;
  localparam logic [19:0] DESC_CRC_FIRST = 20'h01A04;
  localparam logic [19:0] DESC_CRC_LAST = 20'h01A07;
  localparam logic [19:0] DESC_REF15_30 = 20'h01A1A;
  localparam logic [19:0] DESC_REF15_105 = 20'h01A1C;
  localparam logic [19:0] DESC_REFTAG = 20'h01A26;
  localparam logic [7:0] REFTAG_VAL = 8'h12;
  localparam logic [7:0] REFLEN_VAL = 8'h0A;
  localparam logic [19:0] DESC_OSC_TAP = 20'h01A30;
  localparam logic [15:0] CRC_POLY = 16'h1021;
  localparam logic [15:0] CRC_SEED = 16'hFFFF;
  localparam int DESC_BYTES = 50;
  localparam int TINY_BYTES = 26;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    MMD_REG_NONE, MMD_REG_RSV, MMD_REG_TINY, MMD_REG_PERIPH, MMD_REG_BOOTLO,
    MMD_REG_INFO, MMD_REG_DESC, MMD_REG_RAM, MMD_REG_PROG, MMD_REG_BOOTHI
  } mmd_region_t;
  typedef enum {MMD_CRC_IDLE, MMD_CRC_RUN, MMD_CRC_DONE} mmd_crc_state_t;
endpackage

// ---- src/mmd_decoder.sv ----
/*
  Memory map decoder and access checker: classifies each CPU bus cycle, answers reads
  of the reserved words, tiny RAM and descriptor record, and gates writes to ROM and
  locked nonvolatile regions into one-cycle write enables for the storage behind it.
  Assumes a single-cycle CPU bus on mclk; apart from tiny RAM and the descriptor record, memories and peripherals sit outside.
*/
// Operation
// - High boot ROM occupies FFC00h..FFFFFh and never accepts writes.
// - Low boot ROM occupies 1000h..17FFh and never accepts writes.
// - Program lock set blocks writes to main store 8000h..17FFFh.
// - Info lock set blocks writes to information store 1800h..19FFh.
// - Bytes 0..5 read fixed words D032h, 00F0h, 3FFFh and ignore writes.
// - Tiny RAM of 26 bytes at 0006h..001Fh reads and writes.
// - Descriptor checksum word is CRC x16+x12+x5+1 over bytes 1A04h..1A07h.
// - Descriptor holds 1.5 V reference calibration words at 1A1Ah and 1A1Ch.
// - Reference calibration record tag 12h at 1A26h, then length 0Ah.
// - Window 0100h..010Fh selects the special function block.
// - Window 01C0h..01C7h selects the checksum peripheral.
// - Window 0540h..056Fh selects serial unit B0.
// - In a paired port window the second vector sits at 1Eh, first at 0Eh.
`timescale 1ns/1ns
module mmd_decoder
  import mmd_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [1:0] bus_be,
  input wire logic [19:0] bus_addr,
  input wire logic [15:0] bus_wdata,
  input wire logic program_store_lock,
  input wire logic info_store_lock,
  input wire logic [7:0] desc_load_addr,
  input wire logic [7:0] desc_load_data,
  input wire logic desc_load_we,
  input wire logic desc_load_done,
  output logic bus_ack_r,
  output logic [15:0] bus_rdata_r,
  output logic bus_rdata_valid_r,
  output logic [3:0] region_r,
  output logic mem_we_r,
  output logic write_refused_r,
  output logic sel_sfr_r,
  output logic sel_crc_r,
  output logic sel_serb0_r,
  output logic port_vec_r,
  output logic port_vec_hi_r,
  output logic crc_ready_r
);
  // ----------------------------------------------------------------
  // Storage and decode
  // ----------------------------------------------------------------
  logic [7:0] tiny_mem [TINY_BYTES];
  logic [7:0] desc_mem [DESC_BYTES];
  logic [15:0] crc_r;
  logic [1:0] crc_idx_r;
  mmd_crc_state_t crc_state_r;
  mmd_region_t region;
  logic writable;
  logic [19:0] tiny_off;
  logic [19:0] desc_off;
  logic [19:0] port_off;
  logic [15:0] rd_word;

  function automatic logic in_rng(input logic [19:0] a, input logic [19:0] lo,
                                  input logic [19:0] hi);
    in_rng = (a >= lo) && (a <= hi);
  endfunction

  // Region classification; ranges do not overlap so order is free
  always_comb
  begin
    region = MMD_REG_NONE;
    if (in_rng(bus_addr, RSV_LO, RSV_HI)) region = MMD_REG_RSV;
    else if (in_rng(bus_addr, TINY_LO, TINY_HI)) region = MMD_REG_TINY;
    else if (in_rng(bus_addr, PERIPH_LO, PERIPH_HI)) region = MMD_REG_PERIPH;
    else if (in_rng(bus_addr, BOOTLO_LO, BOOTLO_HI)) region = MMD_REG_BOOTLO;
    else if (in_rng(bus_addr, INFO_LO, INFO_HI)) region = MMD_REG_INFO;
    else if (in_rng(bus_addr, DESC_LO, DESC_HI)) region = MMD_REG_DESC;
    else if (in_rng(bus_addr, RAM_LO, RAM_HI)) region = MMD_REG_RAM;
    else if (in_rng(bus_addr, PROG_LO, PROG_HI)) region = MMD_REG_PROG;
    else if (in_rng(bus_addr, BOOTHI_LO, BOOTHI_HI)) region = MMD_REG_BOOTHI;
  end

  // Write permission per region; descriptor is only loadable by the factory port
  always_comb
  begin
    case (region)
      MMD_REG_TINY: writable = 1'b1;
      MMD_REG_PERIPH: writable = 1'b1;
      MMD_REG_RAM: writable = 1'b1;
      MMD_REG_INFO: writable = !info_store_lock;
      MMD_REG_PROG: writable = !program_store_lock;
      MMD_REG_RSV: writable = 1'b0;
      MMD_REG_BOOTLO: writable = 1'b0;
      MMD_REG_BOOTHI: writable = 1'b0;
      default: writable = 1'b0;
    endcase
  end

  assign tiny_off = bus_addr - TINY_LO;
  assign desc_off = bus_addr - DESC_LO;
  assign port_off = bus_addr - PORT_BASE;

  // Read data for the regions answered locally, little-endian word pairs
  always_comb
  begin
    rd_word = 16'h0000;
    case (region)
      MMD_REG_RSV:
      begin
        case (bus_addr[2:1])
          2'b00: rd_word = RSV_WORD0;
          2'b01: rd_word = RSV_WORD1;
          default: rd_word = RSV_WORD2;
        endcase
      end
      MMD_REG_TINY:
      begin
        rd_word[7:0] = tiny_mem[tiny_off[4:0]];
        if (tiny_off[4:0] < 5'(TINY_BYTES - 1))
          rd_word[15:8] = tiny_mem[tiny_off[4:0] + 5'h01];
      end
      MMD_REG_DESC:
      begin
        if (bus_addr[19:1] == DESC_CRC_ADDR[19:1])
          rd_word = crc_r;
        // Tag and length are fixed so the record reads right before any load
        else if (bus_addr[19:1] == DESC_REFTAG[19:1])
          rd_word = {REFLEN_VAL, REFTAG_VAL};
        else
        begin
          // calibration and tap words come from the loaded record
          rd_word[7:0] = desc_mem[desc_off[5:0]];
          if (desc_off[5:0] < 6'(DESC_BYTES - 1))
            rd_word[15:8] = desc_mem[desc_off[5:0] + 6'h01];
        end
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // ----------------------------------------------------------------
  // Local memories
  // ----------------------------------------------------------------
  // Tiny RAM writes honour byte enables; refused cycles never reach it
  always_ff @(posedge mclk)
  begin
    if (bus_req && bus_we && region == MMD_REG_TINY)
    begin
      if (bus_be[0]) tiny_mem[tiny_off[4:0]] <= bus_wdata[7:0];
      if (bus_be[1] && tiny_off[4:0] < 5'(TINY_BYTES - 1))
        tiny_mem[tiny_off[4:0] + 5'h01] <= bus_wdata[15:8];
    end
  end

  // Descriptor record is filled only through the load port, not by the CPU
  always_ff @(posedge mclk)
  begin
    if (desc_load_we && desc_load_addr < 8'(DESC_BYTES))
      desc_mem[desc_load_addr[5:0]] <= desc_load_data;
  end

  // ----------------------------------------------------------------
  // Descriptor checksum
  // ----------------------------------------------------------------
  // One byte per cycle over 1A04h..1A07h after the record load completes
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      crc_state_r <= MMD_CRC_IDLE;
      crc_r <= CRC_SEED;
      crc_idx_r <= 2'b00;
      crc_ready_r <= 1'b0;
    end
    else
    begin
      case (crc_state_r)
        MMD_CRC_IDLE:
        begin
          if (desc_load_done)
          begin
            crc_state_r <= MMD_CRC_RUN;
            crc_r <= CRC_SEED;
            crc_idx_r <= 2'b00;
            crc_ready_r <= 1'b0;
          end
        end
        MMD_CRC_RUN:
        begin
          crc_r <= crc_byte(crc_r,
            desc_mem[6'(DESC_CRC_FIRST - DESC_LO) + {4'h0, crc_idx_r}]);
          crc_idx_r <= crc_idx_r + 2'b01;
          if (crc_idx_r == 2'(DESC_CRC_LAST - DESC_CRC_FIRST))
            crc_state_r <= MMD_CRC_DONE;
        end
        MMD_CRC_DONE:
        begin
          crc_ready_r <= 1'b1;
          crc_state_r <= MMD_CRC_IDLE;
        end
        default: crc_state_r <= MMD_CRC_IDLE;
      endcase
    end
  end

  // MSB-first CRC step for one byte
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] v;
    v = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++)
      v = v[15] ? ((v << 1) ^ CRC_POLY) : (v << 1);
    crc_byte = v;
  endfunction

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  // Every request is answered next cycle; refusal withholds the write enable and raises write_refused_r
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      bus_ack_r <= 1'b0;
      bus_rdata_r <= 16'h0000;
      bus_rdata_valid_r <= 1'b0;
      region_r <= 4'h0;
      mem_we_r <= 1'b0;
      write_refused_r <= 1'b0;
    end
    else
    begin
      bus_ack_r <= bus_req;
      bus_rdata_valid_r <= bus_req && !bus_we;
      bus_rdata_r <= (bus_req && !bus_we) ? rd_word : 16'h0000;
      region_r <= bus_req ? 4'(region) : 4'h0;
      mem_we_r <= bus_req && bus_we && writable;
      write_refused_r <= bus_req && bus_we && !writable;
    end
  end

  // Peripheral selects, registered with the answer
  always_ff @(posedge mclk or posedge reset)
  begin
    if (reset)
    begin
      sel_sfr_r <= 1'b0;
      sel_crc_r <= 1'b0;
      sel_serb0_r <= 1'b0;
      port_vec_r <= 1'b0;
      port_vec_hi_r <= 1'b0;
    end
    else
    begin
      sel_sfr_r <= bus_req && in_rng(bus_addr, SFR_BASE, SFR_BASE + SFR_SIZE - 20'h1);
      sel_crc_r <= bus_req && in_rng(bus_addr, CRCP_BASE, CRCP_BASE + CRCP_SIZE - 20'h1);
      sel_serb0_r <= bus_req
        && in_rng(bus_addr, SERB0_BASE, SERB0_BASE + SERB0_SIZE - 20'h1);
      port_vec_r <= bus_req && in_rng(bus_addr, PORT_BASE, PORT_BASE + PORT_SIZE - 20'h1)
        && ((port_off[4:0] & PORT_WIN_MASK) == PORT_VEC_LO
        || (port_off[4:0] & PORT_WIN_MASK) == PORT_VEC_HI);
      port_vec_hi_r <= (port_off[4:0] & PORT_WIN_MASK) == PORT_VEC_HI;
    end
  end
endmodule

// ---- dv/mmd_decoder_chk_sva.sv ----
/*
  Checker for the memory map decoder: answer timing, write refusal, window selects, checksum.
  Assumes it is bound to mmd_decoder and sees only that module's ports.
*/
`timescale 1ns/1ns
module mmd_decoder_chk
  import mmd_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic bus_req,
  input wire logic bus_we,
  input wire logic [19:0] bus_addr,
  input wire logic program_store_lock,
  input wire logic info_store_lock,
  input wire logic desc_load_done,
  input wire logic bus_ack_r,
  input wire logic [15:0] bus_rdata_r,
  input wire logic bus_rdata_valid_r,
  input wire logic mem_we_r,
  input wire logic write_refused_r,
  input wire logic sel_sfr_r,
  input wire logic sel_crc_r,
  input wire logic sel_serb0_r,
  input wire logic port_vec_r,
  input wire logic port_vec_hi_r,
  input wire logic crc_ready_r
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  logic [2:0] win_r;
  // Window hits kept a cycle so the selects can be tied to their address
  always_ff @(posedge mclk or posedge reset)
    if (reset)
      win_r <= 3'h0;
    else
      win_r <= {bus_addr inside {[SFR_BASE:SFR_BASE + SFR_SIZE - 20'h1]},
                bus_addr inside {[CRCP_BASE:CRCP_BASE + CRCP_SIZE - 20'h1]},
                bus_addr inside {[SERB0_BASE:SERB0_BASE + SERB0_SIZE - 20'h1]}};
  AST_ACK: assert property (bus_req |=> bus_ack_r && bus_rdata_valid_r != $past(bus_we))
    else $error("bus cycle not answered next cycle");
  AST_BOOTHI: assert property (bus_req && bus_we && bus_addr >= BOOTHI_LO
    |=> write_refused_r && !mem_we_r) else $error("high boot ROM write accepted");
  AST_BOOTLO: assert property (bus_req && bus_we
    && bus_addr inside {[BOOTLO_LO:BOOTLO_HI]} |=> write_refused_r && !mem_we_r)
    else $error("low boot ROM write accepted");
  AST_PROG: assert property (bus_req && bus_we && program_store_lock
    && bus_addr inside {[PROG_LO:PROG_HI]} |=> write_refused_r && !mem_we_r)
    else $error("locked main write");
  AST_INFO: assert property (bus_req && bus_we && info_store_lock
    && bus_addr inside {[INFO_LO:INFO_HI]} |=> write_refused_r && !mem_we_r)
    else $error("locked info write");
  AST_RSV: assert property (bus_req && !bus_we && bus_addr <= RSV_HI |=> bus_rdata_r ==
    ($past(bus_addr[2:1]) == 2'h0 ? RSV_WORD0
    : $past(bus_addr[2:1]) == 2'h1 ? RSV_WORD1 : RSV_WORD2))
    else $error("reserved word wrong");
  AST_SFR: assert property (bus_req |=> sel_sfr_r == win_r[2])
    else $error("special function select wrong");
  AST_CRCP: assert property (bus_req |=> sel_crc_r == win_r[1])
    else $error("checksum unit select wrong");
  AST_SERB0: assert property (bus_req |=> sel_serb0_r == win_r[0])
    else $error("serial unit select wrong");
  AST_PVEC: assert property (bus_req && bus_addr inside {[PORT_BASE:20'h0025F]} &&
    bus_addr[3:0] == 4'hE |=> port_vec_r && port_vec_hi_r == $past(bus_addr[4]))
    else $error("port vector decode wrong");
  AST_CRC: assert property (desc_load_done |=> !crc_ready_r [*5] ##1 crc_ready_r)
    else $error("checksum ready timing wrong");
endmodule
bind mmd_decoder mmd_decoder_chk u_chk (.mclk, .reset, .bus_req, .bus_we, .bus_addr,
  .program_store_lock, .info_store_lock, .desc_load_done, .bus_ack_r, .bus_rdata_r,
  .bus_rdata_valid_r, .mem_we_r, .write_refused_r, .sel_sfr_r, .sel_crc_r, .sel_serb0_r,
  .port_vec_r, .port_vec_hi_r, .crc_ready_r);

// ---- dv/mmd_cpu_model.sv ----
/*
  Processor bus master model: one access per call, request raised for a single cycle.
  Assumes the decoder answers on the edge after it takes the request.
*/
`timescale 1ns/1ns
module mmd_cpu_model
(
  input wire logic mclk,
  input wire logic bus_ack_r,
  input wire logic [15:0] bus_rdata_r,
  output logic bus_req,
  output logic bus_we,
  output logic [1:0] bus_be,
  output logic [19:0] bus_addr,
  output logic [15:0] bus_wdata
);
  initial
    {bus_req, bus_we, bus_be, bus_addr, bus_wdata} = '0;
  // Request stands one cycle only: a held level would be taken as a second access
  task automatic access(input logic we, input logic [19:0] a, input logic [15:0] wd,
    input logic [1:0] be, output logic [15:0] rd, output logic ok);
    rd = 16'h0000;
    ok = 1'b0;
    @(posedge mclk) #1;
    bus_req = 1'b1;
    bus_we = we;
    bus_be = be;
    bus_addr = a;
    bus_wdata = wd;
    @(posedge mclk) #1;
    bus_req = 1'b0;
    bus_addr = ~a; // Released lines show garbage, not the last value
    bus_wdata = ~wd;
    for (int i = 0; i < 4 && !ok; i++)
      if (bus_ack_r === 1'b1)
        {ok, rd} = {1'b1, bus_rdata_r};
      else
        @(posedge mclk) #1;
  endtask
endmodule

// ---- dv/tb_memory_map_decoder.sv ----
/*
  Testbench for the memory map decoder: a table of bus cycles, then byte enables,
  descriptor load with checksum, and a reset in mid-run.
  Assumes mmd_cpu_model as bus master and the checker bound to the design.
*/
`timescale 1ns/1ns
module tb_memory_map_decoder
  import mmd_pkg::*;
;
  typedef struct packed {
    logic [3:0] ctl; // write, main lock, info lock, refused
    logic [19:0] a;
    logic [15:0] wd, rd;
    logic [3:0] rg;
    logic [4:0] sel;
  } mmd_row_t;
  logic mclk, reset, bus_req, bus_we, program_store_lock, info_store_lock, ok;
  logic desc_load_we, desc_load_done, bus_ack_r, bus_rdata_valid_r, mem_we_r;
  logic write_refused_r, sel_sfr_r, sel_crc_r, sel_serb0_r, port_vec_r, port_vec_hi_r;
  logic crc_ready_r;
  logic [1:0] bus_be;
  logic [3:0] region_r;
  logic [7:0] desc_load_addr, desc_load_data;
  logic [15:0] bus_wdata, bus_rdata_r, rd;
  logic [19:0] bus_addr;
  logic [27:0] got_row, exp_row;
  int fails, num_checks, n;
  mmd_row_t rows [20] = '{
    '{4'h0, 20'h00000, 16'h0, 16'hD032, 4'h1, 5'h0},
    '{4'h0, 20'h00002, 16'h0, 16'h00F0, 4'h1, 5'h0},
    '{4'h0, 20'h00004, 16'h0, 16'h3FFF, 4'h1, 5'h0},
    '{4'h9, 20'h00000, 16'h1234, 16'h0, 4'h1, 5'h0},
    '{4'h0, 20'h00000, 16'h0, 16'hD032, 4'h1, 5'h0},
    '{4'h8, 20'h00006, 16'hA55A, 16'h0, 4'h2, 5'h0},
    '{4'h0, 20'h00006, 16'h0, 16'hA55A, 4'h2, 5'h0},
    '{4'h9, 20'h017FE, 16'h1, 16'h0, 4'h4, 5'h0},
    '{4'h9, 20'hFFFFE, 16'h1, 16'h0, 4'h9, 5'h0},
    '{4'hD, 20'h17FFE, 16'h1, 16'h0, 4'h8, 5'h0},
    '{4'h8, 20'h08000, 16'h1, 16'h0, 4'h8, 5'h0},
    '{4'hB, 20'h01800, 16'h1, 16'h0, 4'h5, 5'h0},
    '{4'h0, 20'h01A26, 16'h0, 16'h0A12, 4'h6, 5'h0},
    '{4'h0, 20'h0010E, 16'h0, 16'h0, 4'h3, 5'h10},
    '{4'h0, 20'h00110, 16'h0, 16'h0, 4'h3, 5'h0},
    '{4'h0, 20'h001C6, 16'h0, 16'h0, 4'h3, 5'h08},
    '{4'h0, 20'h0056E, 16'h0, 16'h0, 4'h3, 5'h04},
    '{4'h0, 20'h0020E, 16'h0, 16'h0, 4'h3, 5'h02},
    '{4'h0, 20'h0025E, 16'h0, 16'h0, 4'h3, 5'h03},
    '{4'h9, 20'h04000, 16'h1, 16'h0, 4'h0, 5'h0}};
  logic [15:0] loads [10] = '{16'h0421, 16'h0522, 16'h0623, 16'h0724, 16'h1A34, 16'h1B12,
    16'h1C78, 16'h1D56, 16'h30BC, 16'h319A};
  mmd_decoder dut (.mclk, .reset, .bus_req, .bus_we, .bus_be, .bus_addr, .bus_wdata,
    .program_store_lock, .info_store_lock, .desc_load_addr, .desc_load_data, .desc_load_we,
    .desc_load_done, .bus_ack_r, .bus_rdata_r, .bus_rdata_valid_r, .region_r, .mem_we_r,
    .write_refused_r, .sel_sfr_r, .sel_crc_r, .sel_serb0_r, .port_vec_r, .port_vec_hi_r,
    .crc_ready_r);
  mmd_cpu_model cpu (.mclk, .bus_ack_r, .bus_rdata_r, .bus_req, .bus_we, .bus_be, .bus_addr,
    .bus_wdata);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // A missing answer ends the run at once, since later results would be meaningless
  task automatic acc(input logic we, input logic [19:0] a, input logic [15:0] wd,
    input logic [1:0] be);
    cpu.access(we, a, wd, be, rd, ok);
    if (!ok)
    begin
      fails++;
      test_done();
    end
  endtask
  // Model checksum, MSB first, worked out independently of the design
  function automatic logic [15:0] crc16(input logic [31:0] d);
    logic [15:0] c;
    c = CRC_SEED;
    for (int i = 31; i >= 0; i--)
      c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? CRC_POLY : 16'h0000);
    return c;
  endfunction
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  initial
  begin
    {reset, program_store_lock, info_store_lock, desc_load_we, desc_load_done} = 5'h10;
    {desc_load_addr, desc_load_data} = 16'h0000;
    repeat (12) @(posedge mclk);
    #1 reset = 1'b0;
    foreach (rows[i])
    begin
      {program_store_lock, info_store_lock} = rows[i].ctl[2:1];
      acc(rows[i].ctl[3], rows[i].a, rows[i].wd, 2'h3);
      // Accepted writes must raise the store enable; reads must flag their data
      exp_row = {rows[i].ctl[0], rows[i].ctl[3] & ~rows[i].ctl[0], ~rows[i].ctl[3], rows[i].rg,
        rows[i].rd, rows[i].sel};
      got_row = {write_refused_r, mem_we_r, bus_rdata_valid_r, region_r, rd, sel_sfr_r,
        sel_crc_r, sel_serb0_r, port_vec_r, port_vec_r & port_vec_hi_r};
      check(got_row, exp_row);
    end
    acc(1'b1, 20'h00008, 16'hFFFF, 2'h3);
    acc(1'b1, 20'h00008, 16'h0000, 2'h1);
    acc(1'b0, 20'h00008, 16'h0000, 2'h3);
    check(rd, 16'hFF00);
    foreach (loads[i])
    begin
      @(posedge mclk) #1;
      {desc_load_addr, desc_load_data, desc_load_we} = {loads[i], 1'b1};
    end
    @(posedge mclk) #1;
    {desc_load_we, desc_load_done} = 2'h1;
    @(posedge mclk) #1;
    desc_load_done = 1'b0;
    for (n = 0; n < 12 && crc_ready_r !== 1'b1; n++)
      @(posedge mclk) #1;
    check(n < 12, 1'b1);
    if (n == 12)
      test_done();
    acc(1'b0, DESC_CRC_ADDR, 16'h0000, 2'h3);
    check(rd, crc16(32'h21222324));
    acc(1'b0, DESC_REF15_30, 16'h0000, 2'h3);
    check(rd, 16'h1234);
    acc(1'b0, DESC_REF15_105, 16'h0000, 2'h3);
    check(rd, 16'h5678);
    acc(1'b0, DESC_OSC_TAP, 16'h0000, 2'h3);
    check(rd, 16'h9ABC);
    reset = 1'b1;
    repeat (2) @(posedge mclk);
    #1 reset = 1'b0;
    check({bus_ack_r, crc_ready_r, region_r}, 6'h00);
    acc(1'b0, DESC_CRC_ADDR, 16'h0000, 2'h3);
    check(rd, CRC_SEED);
    test_done();
  end
endmodule
